// >>> hw/motor_ctrl_pkg.sv
/*
  Constants for the motor controller tacho, compare update and emergency block.
  Assumes a word-addressed Wishbone map: byte address is four times the index.
*/
// Operation
// - One-shot capture stops counting, latches counter, flags capture, clears if selected.
// - One-shot top byte match with compare stops counter and flags overflow.
// - Continuous capture latches counter and flags capture without stopping.
// - Continuous top byte match flags overflow and keeps counting.
// - Tacho compare resets to ffh; match clears counter and flags overflow.
// - Transfer mode bit: 0 hardware, 1 software; events flagged in both modes.
// - Writing 1 to the PWM clear bit clears the PWM counter; software resets it.
// - Active phase and period compares are zero after reset.
// - Hardware mode: counters both zero reloads repetition, copies preloads, flags transfer.
// - An event recurring while still pending is dropped silently.
// - Software go with select bits updates chosen registers; go self-clears.
// - Software mode performs no automatic preload copy on transfer.
// - Repetition counter is decremented at once when software updates it.
// - Outputs from override bits, else dead-time outputs, else plain PWM.
// - Emergency enable resets to 0; while clear the pin passes straight to core.
// - Enabled emergency sets pending, floats outputs, requests core, clears drive enable.
// - Emergency pending bit clears by writing 0 only while emergency is inactive.
// - Captured tacho value reads as two read-only bytes.
// - Pending bit layout fixed; each sets only when its event enable is 1.
// - Phase flags: always in classical mode, chosen direction only when centred.
// - Software cannot set pending bits, only clear them with a mask load.
// - Tacho divider high holds four bits, upper bits zero, reset 00h.
// - Edge field: 00 none, 01 falling, 10 rising, 11 both.
// - Software capture bit captures when software source selected and self-clears.
package motor_ctrl_pkg;
  localparam logic [7:0] IDX_CAPT_HI = 8'hf0;
  localparam logic [7:0] IDX_CAPT_LO = 8'hf1;
  localparam logic [7:0] IDX_TACHO_OVERFLOW_COMPARE    = 8'hf2;
  localparam logic [7:0] IDX_PEND    = 8'hf3;
  localparam logic [7:0] IDX_TDIV_HI = 8'hf4;
  localparam logic [7:0] IDX_TDIV_LO = 8'hf5;
  localparam logic [7:0] IDX_PDIV    = 8'hf6;
  localparam logic [7:0] IDX_REP     = 8'hf7;
  localparam logic [7:0] IDX_CTRL0   = 8'hf8;
  localparam logic [7:0] IDX_CTRL1   = 8'hf9;
  localparam logic [7:0] IDX_CTRL2   = 8'hfa;
  localparam logic [7:0] IDX_OVR     = 8'hfb;
  localparam logic [7:0] IDX_VECTOR  = 8'hfc;
  localparam logic [7:0] IDX_EVT_EN  = 8'hfd;
  localparam logic [7:0] IDX_MISC    = 8'hfe;
  localparam logic [7:0] IDX_PRE0    = 8'he0;
  localparam logic [7:0] IDX_PRE_U   = 8'he1;
  localparam logic [7:0] IDX_PRE_V   = 8'he2;
  localparam logic [7:0] IDX_PRE_W   = 8'he3;
  localparam int unsigned C0_TCNT_EN = 6;
  localparam int unsigned C0_PWM_EN  = 5;
  localparam int unsigned C0_TCLR    = 4;
  localparam int unsigned C0_PCLR    = 3;
  localparam int unsigned C0_CENTRED = 2;
  localparam int unsigned C0_UP      = 1;
  localparam int unsigned C0_COMPL   = 0;
  localparam int unsigned C1_EMRG_EN = 6;
  localparam int unsigned C1_CLR_CPT = 5;
  localparam int unsigned C1_SRC_SW  = 4;
  localparam int unsigned C1_SW_CAPT = 3;
  localparam int unsigned C1_ONESHOT = 2;
  localparam int unsigned ES_FALL    = 0;
  localparam int unsigned ES_RISE    = 1;
  localparam int unsigned C2_REP_SEL = 6;
  localparam int unsigned C2_W_SEL   = 5;
  localparam int unsigned C2_V_SEL   = 4;
  localparam int unsigned C2_U_SEL   = 3;
  localparam int unsigned C2_P_SEL   = 2;
  localparam int unsigned C2_GO      = 1;
  localparam int unsigned C2_SWMODE  = 0;
  localparam int unsigned OV_SEL     = 7;
  localparam int unsigned OV_DRIVE   = 6;
  localparam int unsigned VEC_EMRG   = 3;
  localparam int unsigned MISC_LEVEL = 0;
  localparam int unsigned MISC_DIR   = 1;
  localparam logic [7:0] RST_TACHO_OVERFLOW_COMPARE    = 8'hff;
  localparam logic [7:0] RST_CTRL0   = 8'h83;
  localparam logic [7:0] CTRL_MASK   = 8'h7f;
endpackage

// >>> hw/motor_rate_div.sv
/*
  Rate divider: one-cycle tick every div+1 clocks while running.
  Assumes i_div is steady while running; stopping restarts the count.
*/
`timescale 1ns/1ns
`default_nettype none
module motor_rate_div #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_div,
  output logic              o_tick
);
  logic [W-1:0] cnt_q;

  assign o_tick = i_run & (cnt_q == i_div);

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || !i_run || o_tick)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  AST_DIV_STEP: assert property (i_run && !o_tick && $stable(i_div) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("divider count did not advance");
  AST_DIV_WRAP: assert property (o_tick |=> cnt_q == '0)
    else $error("divider did not restart after tick");
endmodule // motor_rate_div
`default_nettype wire

// >>> hw/motor_flag_reg.sv
/*
  Sticky event flags: hardware sets, a mask write clears bits written as 0.
  Assumes i_set is already qualified by the event enables.
*/
`timescale 1ns/1ns
`default_nettype none
module motor_flag_reg #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_set,
  input  wire logic         i_wr,
  input  wire logic [W-1:0] i_wdat,
  output logic [W-1:0]      o_flags
);
  logic [W-1:0] kept;

  // Ones in the mask keep a bit; a new event wins over a clear
  assign kept = i_wr ? (o_flags & i_wdat) : o_flags;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_flags <= '0;
    else
      o_flags <= kept | i_set;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  AST_FLAG_SET: assert property (1'b1 |=> (o_flags & $past(i_set)) == $past(i_set))
    else $error("event did not set its flag");
  AST_FLAG_NO_SW_SET: assert property (i_set == '0 |=> (o_flags & ~$past(o_flags)) == '0)
    else $error("flag rose without an event");
  AST_FLAG_MASK: assert property (i_wr && i_set == '0 |=> o_flags == $past(o_flags & i_wdat))
    else $error("mask write did not clear only zero bits");
endmodule // motor_flag_reg
`default_nettype wire

// >>> hw/motor_tacho_update_irq_ctrl.sv
/*
  Tacho counter, compare update, output select and emergency handling of a
  three-phase motor controller, with a classic Wishbone register slave.
  Assumes the PWM phase waveforms and dead-time outputs come from outside.
*/
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module motor_tacho_update_irq_ctrl #(
  parameter int unsigned ADR_W  = 10,
  parameter int unsigned TCNT_W = 16,
  parameter int unsigned PCNT_W = 10
) (
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic                   o_wb_ack,
  output logic [31:0]            o_wb_dat,
  input  wire logic              i_tacho,
  input  wire logic              i_emergency,
  input  wire logic [2:0]        i_pwm_phase,
  input  wire logic [5:0]        i_deadtime_hl,
  output logic [5:0]             o_motor,
  output logic [5:0]             o_motor_oe,
  output logic                   o_emergency_core
);
  localparam int unsigned CMP_W = PCNT_W + 1;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] b, input logic go);
    return go & (a == b);
  endfunction

  function automatic logic phase_hit(input logic [PCNT_W-1:0] cnt, input logic [CMP_W-1:0] cmp,
                                     input logic centred, input logic up, input logic dir);
    return ({1'b0, cnt} == cmp) & (!centred | (up ^ dir));
  endfunction

  logic              ack_q;
  logic [31:0]       rdat_q;
  logic [31:0]       rd;
  logic [7:0]        tacho_overflow_compare_q;
  logic [3:0]        tdiv_hi_q;
  logic [7:0]        tdiv_lo_q;
  logic [7:0]        pdiv_q;
  logic [7:0]        rep_q;
  logic [7:0]        ctrl0_q;
  logic [7:0]        ctrl0_d;
  logic [7:0]        ctrl1_q;
  logic [7:0]        ctrl1_d;
  logic [7:0]        ctrl2_q;
  logic [7:0]        ctrl2_d;
  logic [7:0]        ovr_q;
  logic [7:0]        ovr_d;
  logic [7:0]        evt_en_q;
  logic [1:0]        misc_q;
  logic [PCNT_W-1:0] pre0_q;
  logic [CMP_W-1:0]  pre_u_q;
  logic [CMP_W-1:0]  pre_v_q;
  logic [CMP_W-1:0]  pre_w_q;
  logic [TCNT_W-1:0] tcnt_q;
  logic [TCNT_W-1:0] capt_q;
  logic              tacho_prev_q;
  logic [PCNT_W-1:0] pcnt_q;
  logic [PCNT_W-1:0] pcnt_d;
  logic              up_q;
  logic              up_d;
  logic [7:0]        rep_cnt_q;
  logic [PCNT_W-1:0] cmp0_q;
  logic [CMP_W-1:0]  cmp_u_q;
  logic [CMP_W-1:0]  cmp_v_q;
  logic [CMP_W-1:0]  cmp_w_q;
  logic              emrg_q;
  logic [7:0]        pend;
  logic              ttick;
  logic              ptick;

  // Bus decode: one transfer per ack, writes land at the acknowledging edge
  wire       req      = i_wb_cyc & i_wb_stb;
  wire [7:0] idx      = i_wb_adr[ADR_W-1:2];
  wire       aligned  = i_wb_adr[1:0] == 2'b00;
  wire       wr_go    = req & i_wb_we & ack_q & i_wb_sel[0] & aligned;
  wire [7:0] wdat     = i_wb_dat[7:0];
  wire       wr_c0    = wr_hit(idx, motor_ctrl_pkg::IDX_CTRL0, wr_go);
  wire       wr_c1    = wr_hit(idx, motor_ctrl_pkg::IDX_CTRL1, wr_go);
  wire       wr_c2    = wr_hit(idx, motor_ctrl_pkg::IDX_CTRL2, wr_go);
  wire       wr_ovr   = wr_hit(idx, motor_ctrl_pkg::IDX_OVR, wr_go);
  wire       wr_pend  = wr_hit(idx, motor_ctrl_pkg::IDX_PEND, wr_go);
  wire       wr_vec   = wr_hit(idx, motor_ctrl_pkg::IDX_VECTOR, wr_go);

  // Tacho side
  wire       tcnt_en  = ctrl0_q[motor_ctrl_pkg::C0_TCNT_EN];
  wire       oneshot  = ctrl1_q[motor_ctrl_pkg::C1_ONESHOT];
  wire [1:0] es       = ctrl1_q[1:0];
  wire       rise     = i_tacho & !tacho_prev_q;
  wire       fall     = !i_tacho & tacho_prev_q;
  wire       hw_capt  = (es[motor_ctrl_pkg::ES_FALL] & fall) | (es[motor_ctrl_pkg::ES_RISE] & rise);
  wire       capt_ev  = ctrl1_q[motor_ctrl_pkg::C1_SRC_SW] ? ctrl1_q[motor_ctrl_pkg::C1_SW_CAPT]
                                                           : hw_capt;
  wire       ovf_ev   = tcnt_en & (tcnt_q[TCNT_W-1 -: 8] == tacho_overflow_compare_q);
  wire       tclear   = ctrl0_q[motor_ctrl_pkg::C0_TCLR] | ovf_ev
                        | (capt_ev & ctrl1_q[motor_ctrl_pkg::C1_CLR_CPT]);
  wire       tstop    = oneshot & (capt_ev | ovf_ev);

  // PWM counter and compare update
  wire       pwm_en   = ctrl0_q[motor_ctrl_pkg::C0_PWM_EN];
  wire       pclr     = ctrl0_q[motor_ctrl_pkg::C0_PCLR];
  wire       centred  = ctrl0_q[motor_ctrl_pkg::C0_CENTRED];
  wire       dir      = misc_q[motor_ctrl_pkg::MISC_DIR];
  wire       step     = pwm_en & ptick & !pclr;
  wire       at_top   = pcnt_q == cmp0_q;
  wire       at_zero  = pcnt_q == '0;
  wire       zero_ev  = step & at_zero;
  wire       cm0_ev   = step & at_top;
  wire       u_ev     = step & phase_hit(pcnt_q, cmp_u_q, centred, up_q, dir);
  wire       v_ev     = step & phase_hit(pcnt_q, cmp_v_q, centred, up_q, dir);
  wire       w_ev     = step & phase_hit(pcnt_q, cmp_w_q, centred, up_q, dir);
  wire       swmode   = ctrl2_q[motor_ctrl_pkg::C2_SWMODE];
  wire       xfer_ev  = zero_ev & (rep_cnt_q == 8'h00);
  wire       hw_load  = xfer_ev & !swmode;
  wire       sw_go    = swmode & ctrl2_q[motor_ctrl_pkg::C2_GO];
  wire [7:0] rep_sw   = (rep_q == 8'h00) ? 8'h00 : rep_q - 8'h01;

  // Emergency
  wire       emrg_act = i_emergency ~^ misc_q[motor_ctrl_pkg::MISC_LEVEL];
  wire       emrg_en  = ctrl1_q[motor_ctrl_pkg::C1_EMRG_EN];
  wire       emrg_set = emrg_en & emrg_act;
  wire       emrg_clr = wr_vec & !wdat[motor_ctrl_pkg::VEC_EMRG] & !emrg_act;
  wire       emrg_d   = emrg_set | (emrg_q & !emrg_clr);

  // Output source select
  wire [5:0] plain    = {{2{i_pwm_phase[2]}}, {2{i_pwm_phase[1]}}, {2{i_pwm_phase[0]}}};
  wire [5:0] motor_d  = ovr_q[motor_ctrl_pkg::OV_SEL] ? ovr_q[5:0]
                      : ctrl0_q[motor_ctrl_pkg::C0_COMPL] ? i_deadtime_hl : plain;
  wire       drive    = ovr_q[motor_ctrl_pkg::OV_DRIVE] & !emrg_q;

  wire [7:0] evt_set  = evt_en_q & {cm0_ev, capt_ev, ovf_ev, xfer_ev,
                                    zero_ev, u_ev, v_ev, w_ev};

  always_comb
  begin
    ctrl0_d = wr_c0 ? wdat : ctrl0_q;
    if (!wr_c0)
      ctrl0_d[motor_ctrl_pkg::C0_TCLR] = 1'b0;
    if (!wr_c0 && tstop)
      ctrl0_d[motor_ctrl_pkg::C0_TCNT_EN] = 1'b0;
    ctrl1_d = (wr_c1 ? wdat : ctrl1_q) & motor_ctrl_pkg::CTRL_MASK;
    if (!wr_c1)
      ctrl1_d[motor_ctrl_pkg::C1_SW_CAPT] = 1'b0;
    ctrl2_d = (wr_c2 ? wdat : ctrl2_q) & motor_ctrl_pkg::CTRL_MASK;
    if (!wr_c2)
      ctrl2_d[motor_ctrl_pkg::C2_GO] = 1'b0;
    ovr_d = wr_ovr ? wdat : ovr_q;
    if (emrg_set)
      ovr_d[motor_ctrl_pkg::OV_DRIVE] = 1'b0;
  end

  always_comb
  begin
    pcnt_d = pcnt_q;
    up_d   = up_q;
    if (pclr)
    begin
      pcnt_d = '0;
      up_d   = 1'b1;
    end
    else if (step)
    begin
      if (!centred)
      begin
        pcnt_d = at_top ? '0 : pcnt_q + 1'b1;
        up_d   = 1'b1;
      end
      else if (up_q)
      begin
        up_d   = !at_top;
        pcnt_d = at_top ? pcnt_q - 1'b1 : pcnt_q + 1'b1;
      end
      else
      begin
        up_d   = at_zero;
        pcnt_d = at_zero ? pcnt_q + 1'b1 : pcnt_q - 1'b1;
      end
    end
  end

  always_comb
  begin
    rd = 32'h0;
    if (aligned)
    begin
      unique case (idx)
        motor_ctrl_pkg::IDX_CAPT_HI: rd = {24'h0, capt_q[TCNT_W-1 -: 8]};
        motor_ctrl_pkg::IDX_CAPT_LO: rd = {24'h0, capt_q[7:0]};
        motor_ctrl_pkg::IDX_TACHO_OVERFLOW_COMPARE:    rd = {24'h0, tacho_overflow_compare_q};
        motor_ctrl_pkg::IDX_PEND:    rd = {24'h0, pend};
        motor_ctrl_pkg::IDX_TDIV_HI: rd = {28'h0, tdiv_hi_q};
        motor_ctrl_pkg::IDX_TDIV_LO: rd = {24'h0, tdiv_lo_q};
        motor_ctrl_pkg::IDX_PDIV:    rd = {24'h0, pdiv_q};
        motor_ctrl_pkg::IDX_REP:     rd = {24'h0, rep_q};
        motor_ctrl_pkg::IDX_CTRL0:   rd = {24'h0, ctrl0_q[7:2], up_q, ctrl0_q[0]};
        motor_ctrl_pkg::IDX_CTRL1:   rd = {24'h0, ctrl1_q};
        motor_ctrl_pkg::IDX_CTRL2:   rd = {24'h0, ctrl2_q};
        motor_ctrl_pkg::IDX_OVR:     rd = {24'h0, ovr_q};
        motor_ctrl_pkg::IDX_VECTOR:  rd = {28'h0, emrg_q, 3'h0};
        motor_ctrl_pkg::IDX_EVT_EN:  rd = {24'h0, evt_en_q};
        motor_ctrl_pkg::IDX_MISC:    rd = {30'h0, misc_q};
        motor_ctrl_pkg::IDX_PRE0:    rd = 32'(pre0_q);
        motor_ctrl_pkg::IDX_PRE_U:   rd = 32'(pre_u_q);
        motor_ctrl_pkg::IDX_PRE_V:   rd = 32'(pre_v_q);
        motor_ctrl_pkg::IDX_PRE_W:   rd = 32'(pre_w_q);
        default:                     rd = 32'h0;
      endcase
    end
  end

  motor_rate_div #(.W(12)) u_tacho_div (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_run     (tcnt_en),
    .i_div     ({tdiv_hi_q, tdiv_lo_q}),
    .o_tick    (ttick)
  );

  motor_rate_div #(.W(8)) u_pwm_div (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_run     (pwm_en),
    .i_div     (pdiv_q),
    .o_tick    (ptick)
  );

  motor_flag_reg #(.W(8)) u_pending (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_set     (evt_set),
    .i_wr      (wr_pend),
    .i_wdat    (wdat),
    .o_flags   (pend)
  );

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end
    else
    begin
      ack_q <= req & !ack_q;
      if (req && !ack_q)
        rdat_q <= rd;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      tacho_overflow_compare_q    <= motor_ctrl_pkg::RST_TACHO_OVERFLOW_COMPARE;
      tdiv_hi_q <= 4'h0;
      tdiv_lo_q <= 8'h00;
      pdiv_q    <= 8'h00;
      rep_q     <= 8'h00;
      evt_en_q  <= 8'h00;
      misc_q    <= 2'h0;
      pre0_q    <= '0;
      pre_u_q   <= '0;
      pre_v_q   <= '0;
      pre_w_q   <= '0;
    end
    else if (wr_go)
    begin
      unique case (idx)
        motor_ctrl_pkg::IDX_TACHO_OVERFLOW_COMPARE:    tacho_overflow_compare_q    <= wdat;
        motor_ctrl_pkg::IDX_TDIV_HI: tdiv_hi_q <= wdat[3:0];
        motor_ctrl_pkg::IDX_TDIV_LO: tdiv_lo_q <= wdat;
        motor_ctrl_pkg::IDX_PDIV:    pdiv_q    <= wdat;
        motor_ctrl_pkg::IDX_REP:     rep_q     <= wdat;
        motor_ctrl_pkg::IDX_EVT_EN:  evt_en_q  <= wdat;
        motor_ctrl_pkg::IDX_MISC:    misc_q    <= wdat[1:0];
        motor_ctrl_pkg::IDX_PRE0:    pre0_q    <= i_wb_dat[PCNT_W-1:0];
        motor_ctrl_pkg::IDX_PRE_U:   pre_u_q   <= i_wb_dat[CMP_W-1:0];
        motor_ctrl_pkg::IDX_PRE_V:   pre_v_q   <= i_wb_dat[CMP_W-1:0];
        motor_ctrl_pkg::IDX_PRE_W:   pre_w_q   <= i_wb_dat[CMP_W-1:0];
        default:                     ;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      ctrl0_q <= motor_ctrl_pkg::RST_CTRL0;
      ctrl1_q <= 8'h00;
      ctrl2_q <= 8'h00;
      ovr_q   <= 8'h00;
      emrg_q  <= 1'b0;
    end
    else
    begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      ovr_q   <= ovr_d;
      emrg_q  <= emrg_d;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      tcnt_q       <= '0;
      tacho_prev_q <= 1'b0;
    end
    else
    begin
      tacho_prev_q <= i_tacho;
      if (tclear)
        tcnt_q <= '0;
      else if (tcnt_en && ttick)
        tcnt_q <= tcnt_q + 1'b1;
    end
  end

  // Capture holds no reset value
  always_ff @(posedge i_mclk)
  begin
    if (capt_ev)
      capt_q <= tcnt_q;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      pcnt_q    <= '0;
      up_q      <= 1'b1;
      rep_cnt_q <= 8'h00;
      cmp0_q    <= '0;
      cmp_u_q   <= '0;
      cmp_v_q   <= '0;
      cmp_w_q   <= '0;
    end
    else
    begin
      pcnt_q <= pcnt_d;
      up_q   <= up_d;
      if (sw_go && ctrl2_q[motor_ctrl_pkg::C2_REP_SEL])
        rep_cnt_q <= rep_sw;
      else if (xfer_ev)
        rep_cnt_q <= rep_q;
      else if (zero_ev)
        rep_cnt_q <= rep_cnt_q - 8'h01;
      if (hw_load || (sw_go && ctrl2_q[motor_ctrl_pkg::C2_P_SEL]))
        cmp0_q <= pre0_q;
      if (hw_load || (sw_go && ctrl2_q[motor_ctrl_pkg::C2_U_SEL]))
        cmp_u_q <= pre_u_q;
      if (hw_load || (sw_go && ctrl2_q[motor_ctrl_pkg::C2_V_SEL]))
        cmp_v_q <= pre_v_q;
      if (hw_load || (sw_go && ctrl2_q[motor_ctrl_pkg::C2_W_SEL]))
        cmp_w_q <= pre_w_q;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_motor          <= 6'h00;
      o_motor_oe       <= 6'h00;
      o_emergency_core <= 1'b0;
    end
    else
    begin
      o_motor          <= motor_d;
      o_motor_oe       <= {6{drive}};
      o_emergency_core <= emrg_en ? emrg_q : i_emergency;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  AST_ONESHOT_CAPT: assert property (oneshot && capt_ev && !wr_c0 |=> !tcnt_en)
    else $error("one-shot capture did not stop counter");
  AST_ONESHOT_OVF: assert property (oneshot && ovf_ev && !wr_c0 |=> !tcnt_en && tcnt_q == '0)
    else $error("one-shot overflow did not stop and clear");
  AST_CAPT_LATCH: assert property (capt_ev |=> capt_q == $past(tcnt_q))
    else $error("capture did not latch counter");
  AST_CONT_RUN: assert property (!oneshot && tcnt_en && ovf_ev && !wr_c0 |=> tcnt_en)
    else $error("continuous overflow stopped counter");
  AST_OVF_CLEAR: assert property (ovf_ev |=> tcnt_q == '0)
    else $error("overflow did not clear tacho counter");
  AST_RESET_CMP: assert property ($fell(i_sys_rst) |-> cmp0_q == '0 && cmp_u_q == '0)
    else $error("compares not zero after reset");
  AST_HW_LOAD: assert property (hw_load |=> cmp0_q == $past(pre0_q) && rep_cnt_q == $past(rep_q))
    else $error("hardware transfer did not load");
  AST_SW_NOLOAD: assert property (swmode && !ctrl2_q[motor_ctrl_pkg::C2_GO] |=> $stable(cmp_u_q))
    else $error("software mode loaded compare on its own");
  AST_SW_GO_CLR: assert property (ctrl2_q[motor_ctrl_pkg::C2_GO] && !wr_c2 |=> !ctrl2_q[motor_ctrl_pkg::C2_GO])
    else $error("software go bit not cleared");
  AST_PWM_CLR: assert property (pclr |=> pcnt_q == '0)
    else $error("PWM clear did not clear counter");
  AST_OUT_OVR: assert property (ovr_q[motor_ctrl_pkg::OV_SEL] |=> o_motor == $past(ovr_q[5:0]))
    else $error("override bits not driven to outputs");
  AST_EMRG_FLOAT: assert property (emrg_set |-> ##2 o_motor_oe == 6'h00 && o_emergency_core)
    else $error("emergency did not float outputs and request core");
  AST_EMRG_PASS: assert property (!emrg_en |=> o_emergency_core == $past(i_emergency))
    else $error("emergency pin not passed to core");
  AST_EMRG_HOLD: assert property (emrg_q && emrg_act |=> emrg_q)
    else $error("emergency pending cleared while active");
endmodule // motor_tacho_update_irq_ctrl
`default_nettype wire

// >>> dv/motor_field_model.sv
/* Tacho sensor and emergency pin model.
   Assumes its tasks are called just after a clock edge. */
`timescale 1ns/1ns
`default_nettype none
module motor_field_model (
  input  wire logic i_mclk,
  output logic      o_tacho,
  output logic      o_emergency
);
  initial
  begin
    o_tacho = 1'b0;
    o_emergency = 1'b0;
  end
  task automatic tacho_pulse();
    @(posedge i_mclk) o_tacho <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_tacho <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic emergency_level(input logic lvl);
    @(posedge i_mclk) o_emergency <= lvl;
  endtask
endmodule // motor_field_model
`default_nettype wire

// >>> dv/motor_tacho_update_irq_ctrl_tb.sv
/* Register-level bench for the tacho and emergency block.
   Assumes one clock and a classic Wishbone slave. */
`timescale 1ns/1ns
`default_nettype none
module motor_tacho_update_irq_ctrl_tb;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic [3:0]  sel  = 4'hf;
  logic [2:0]  ph   = 3'h5;
  logic [5:0]  dt   = 6'h15;
  logic        we   = 1'b0;
  logic [9:0]  adr  = 10'h000;
  logic [31:0] dat  = 32'h0;
  logic        ack;
  logic [31:0] rdat;
  logic        tacho;
  logic        emrg;
  logic [5:0]  mot;
  logic [5:0]  oe;
  logic        core;
  logic [7:0]  r;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  motor_field_model fm (.i_mclk(mclk), .o_tacho(tacho), .o_emergency(emrg));
  motor_tacho_update_irq_ctrl uut (.i_mclk(mclk), .i_sys_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_tacho(tacho), .i_emergency(emrg),
    .i_pwm_phase(ph), .i_deadtime_hl(dt), .o_motor(mot), .o_motor_oe(oe),
    .o_emergency_core(core));
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      close_out();
    end
  end
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, wd};
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdm(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(r & m, exp);
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdm(motor_ctrl_pkg::IDX_TACHO_OVERFLOW_COMPARE, 8'hff, 8'hff);
    rdm(motor_ctrl_pkg::IDX_PEND, 8'hff, 8'h00);
    rdm(motor_ctrl_pkg::IDX_TDIV_HI, 8'hff, 8'h00);
    rdm(8'h10, 8'hff, 8'h00);
    wb(1'b1, motor_ctrl_pkg::IDX_TDIV_HI, 8'hff);
    rdm(motor_ctrl_pkg::IDX_TDIV_HI, 8'hff, 8'h0f);
    wb(1'b1, motor_ctrl_pkg::IDX_PEND, 8'hff);
    rdm(motor_ctrl_pkg::IDX_PEND, 8'hff, 8'h00);
    fm.emergency_level(1'b1);
    repeat (3) @(posedge mclk);
    chk({7'h0, core}, 8'h01);
    fm.emergency_level(1'b0);
    $display("registers done");
    wb(1'b1, motor_ctrl_pkg::IDX_EVT_EN, 8'h60);
    wb(1'b1, motor_ctrl_pkg::IDX_CTRL1, 8'h02);
    wb(1'b1, motor_ctrl_pkg::IDX_CTRL0, 8'hc3);
    fm.tacho_pulse();
    rdm(motor_ctrl_pkg::IDX_PEND, 8'hff, 8'h40);
    rdm(motor_ctrl_pkg::IDX_CTRL0, 8'h40, 8'h40);
    wb(1'b1, motor_ctrl_pkg::IDX_PEND, 8'hbf);
    rdm(motor_ctrl_pkg::IDX_PEND, 8'hff, 8'h00);
    wb(1'b1, motor_ctrl_pkg::IDX_CTRL1, 8'h06);
    fm.tacho_pulse();
    rdm(motor_ctrl_pkg::IDX_CTRL0, 8'h40, 8'h00);
    rdm(motor_ctrl_pkg::IDX_PEND, 8'h40, 8'h40);
    wb(1'b1, motor_ctrl_pkg::IDX_TACHO_OVERFLOW_COMPARE, 8'h00);
    wb(1'b1, motor_ctrl_pkg::IDX_CTRL0, 8'hc3);
    repeat (4) @(posedge mclk);
    rdm(motor_ctrl_pkg::IDX_PEND, 8'h20, 8'h20);
    rdm(motor_ctrl_pkg::IDX_CTRL0, 8'h40, 8'h00);
    wb(1'b1, motor_ctrl_pkg::IDX_PEND, 8'h00);
    rdm(motor_ctrl_pkg::IDX_PEND, 8'hff, 8'h00);
    wb(1'b1, motor_ctrl_pkg::IDX_CTRL1, 8'h18);
    rdm(motor_ctrl_pkg::IDX_CTRL1, 8'h18, 8'h10);
    rdm(motor_ctrl_pkg::IDX_PEND, 8'h40, 8'h40);
    rdm(motor_ctrl_pkg::IDX_CAPT_HI, 8'hff, 8'h00);
    rdm(motor_ctrl_pkg::IDX_CAPT_LO, 8'hff, 8'h00);
    sel <= 4'he;
    wb(1'b1, motor_ctrl_pkg::IDX_TACHO_OVERFLOW_COMPARE, 8'h55);
    sel <= 4'hf;
    rdm(motor_ctrl_pkg::IDX_TACHO_OVERFLOW_COMPARE, 8'hff, 8'h00);
    $display("tacho done");
    wb(1'b1, motor_ctrl_pkg::IDX_OVR, 8'hea);
    @(posedge mclk);
    chk({2'h0, mot}, 8'h2a);
    chk({2'h0, oe}, 8'h3f);
    wb(1'b1, motor_ctrl_pkg::IDX_OVR, 8'h40);
    @(posedge mclk);
    chk({2'h0, mot}, 8'h15);
    wb(1'b1, motor_ctrl_pkg::IDX_CTRL0, 8'h80);
    @(posedge mclk);
    chk({2'h0, mot}, 8'h33);
    wb(1'b1, motor_ctrl_pkg::IDX_EVT_EN, 8'h70);
    wb(1'b1, motor_ctrl_pkg::IDX_CTRL0, 8'ha0);
    rdm(motor_ctrl_pkg::IDX_PEND, 8'h10, 8'h10);
    $display("outputs done");
    wb(1'b1, motor_ctrl_pkg::IDX_MISC, 8'h01);
    wb(1'b1, motor_ctrl_pkg::IDX_CTRL1, 8'h40);
    fm.emergency_level(1'b1);
    repeat (3) @(posedge mclk);
    chk({1'b0, oe, core}, 8'h01);
    rdm(motor_ctrl_pkg::IDX_OVR, 8'h40, 8'h00);
    wb(1'b1, motor_ctrl_pkg::IDX_VECTOR, 8'h00);
    rdm(motor_ctrl_pkg::IDX_VECTOR, 8'h08, 8'h08);
    fm.emergency_level(1'b0);
    wb(1'b1, motor_ctrl_pkg::IDX_VECTOR, 8'h00);
    rdm(motor_ctrl_pkg::IDX_VECTOR, 8'h08, 8'h00);
    $display("emergency done");
    close_out();
  end
endmodule // motor_tacho_update_irq_ctrl_tb
`default_nettype wire
